// [hw/cmr_core_regs.sv]
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmr_defs.svh"
module cmr_core_regs
  import cmr_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        op_valid_in,
  input  wire cmr_op_t     op_in,
  input  wire logic [3:0]  sel_a_in,
  input  wire logic [3:0]  sel_b_in,
  input  wire logic [31:0] data_in,
  input  wire logic        pfx_valid_in,
  input  wire logic        pfx_long_in,
  input  wire logic [15:0] irq_vec_in,
  input  wire logic [1:0]  irq_line_in,
  output logic      [31:0] rd_data_out,
  output logic      [23:0] addr_out,
  output logic             addr_valid_out,
  output logic      [15:0] io_data_out,
  output logic             io_valid_out,
  output logic      [15:0] mem_data_out,
  output logic      [31:0] vec_addr_out,
  output logic             ext_mode_out,
  output logic             long_mode_out,
  output logic      [1:0]  irq_mode_out,
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);
  cmr_state_t st_q;
  cmr_state_t st_d;

  // word read; file words from the active bank and file, sp, ir and pc shared
  function automatic logic [31:0] get_w(input cmr_state_t s, input logic [3:0] id);
    cmr_file_t f;
    logic [31:0] v;
    f = s.rf[s.sr[`CMR_SR_BANK]][s.sr[`CMR_SR_ALT + s.sr[`CMR_SR_BANK]]];
    case (id)
      `CMR_W_BC: v = f.p1;
      `CMR_W_DE: v = f.p2;
      `CMR_W_HL: v = f.hl;
      `CMR_W_IX: v = f.ix;
      `CMR_W_IY: v = f.iy;
      `CMR_W_SP: v = s.sp;
      `CMR_W_IR: v = s.ir;
      `CMR_W_PC: v = s.pc;
      default:   v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // word write on top of the next state, so bus and strobe updates of this cycle survive;
  // bank and file come from the registered select, a same-cycle bus write cannot redirect it
  // pc is not a load target here
  function automatic cmr_state_t put_w(input cmr_state_t s, input logic [1:0] b, input logic a,
                                       input logic [3:0] id, input logic [31:0] v);
    cmr_state_t r;
    r = s;
    case (id)
      `CMR_W_BC: r.rf[b][a].p1 = v;
      `CMR_W_DE: r.rf[b][a].p2 = v;
      `CMR_W_HL: r.rf[b][a].hl = v;
      `CMR_W_IX: r.rf[b][a].ix = v;
      `CMR_W_IY: r.rf[b][a].iy = v;
      `CMR_W_SP: r.sp = v;
      `CMR_W_IR: r.ir = v;
      default:   r = s;
    endcase
    return r;
  endfunction

  // width-aware merge: 16-bit mode keeps the old upper half
  function automatic logic [31:0] mrg(input logic lw, input logic [31:0] o,
                                      input logic [31:0] v);
    return lw ? v : {o[31:16], v[15:0]};
  endfunction

  // address base; program counter, stack and interrupt bases lose the upper word when compatible
  function automatic logic [31:0] abase(input cmr_state_t s, input logic [3:0] id,
                                        input logic nat);
    logic [31:0] v;
    v = get_w(s, id);
    if (nat && (id == `CMR_W_PC || id == `CMR_W_SP || id == `CMR_W_IR)) begin
      v = {16'h0000, v[15:0]};
    end
    return v;
  endfunction

  // sum wrapping at 16 bits in compatible mode, upper word of data bases kept
  function automatic logic [31:0] aadd(input logic [31:0] b, input logic [31:0] o,
                                       input logic nat);
    logic [31:0] f;
    logic [15:0] l;
    f = b + o;
    l = b[15:0] + o[15:0];
    return nat ? {b[31:16], l} : f;
  endfunction

  logic        nat;
  logic        lw;
  logic [1:0]  bk;
  logic        al;
  logic [31:0] wa;
  logic [31:0] wb;
  logic [31:0] ea;
  logic [16:0] sum;
  logic [4:0]  hsum;
  logic [31:0] msk;
  logic [31:0] nsr;
  logic [15:0] res;

  // next state: bus slave first, then the decoder command
  always_comb begin
    st_d = st_q;
    nat  = !st_q.sr[`CMR_SR_EXT];
    lw   = pfx_valid_in ? pfx_long_in : st_q.sr[`CMR_SR_LW];
    bk   = st_q.sr[`CMR_SR_BANK];
    al   = st_q.sr[`CMR_SR_ALT + bk];
    wa   = get_w(st_q, sel_a_in);
    wb   = get_w(st_q, sel_b_in);
    ea   = 32'h0000_0000;
    sum  = 17'h00000;
    hsum = 5'h00;
    msk  = 32'h0000_0000;
    nsr  = 32'h0000_0000;
    res  = 16'h0000;
    st_d.addr_v = 1'b0;
    st_d.io_v   = 1'b0;
    // avalon: one wait cycle, then the access completes while waitrequest is low
    if ((avs_read_in || avs_write_in) && st_q.wait_r) begin
      st_d.wait_r = 1'b0;
      case (avs_address_in)
        `CMR_A_SR: st_d.bus_rd = st_q.sr;
        `CMR_A_PC: st_d.bus_rd = st_q.pc;
        `CMR_A_SP: st_d.bus_rd = st_q.sp;
        `CMR_A_IR: st_d.bus_rd = st_q.ir;
        `CMR_A_RR: st_d.bus_rd = {24'h000000, st_q.rr};
        default:   st_d.bus_rd = 32'h0000_0000;
      endcase
    end else if (!st_q.wait_r) begin
      st_d.wait_r = 1'b1;
      if (avs_write_in && avs_address_in == `CMR_A_SR) begin
        for (int i = 0; i < 4; i++) begin
          msk[i*8 +: 8] = {8{avs_byteenable_in[i]}};
        end
        nsr = ((avs_writedata_in & msk) | (st_q.sr & ~msk)) & `CMR_SR_MASK;
        // extended mode cannot be cleared by software
        nsr[`CMR_SR_EXT] = st_q.sr[`CMR_SR_EXT] | nsr[`CMR_SR_EXT];
        st_d.sr = nsr;
      end
    end
    if (op_valid_in) begin
      case (op_in)
        CMR_RD_W: st_d.rd = wa;
        CMR_RD_B: begin
          case (sel_a_in)
            `CMR_B_A:   st_d.rd = {24'h000000, st_q.rf[bk][al].acc};
            `CMR_B_F:   st_d.rd = {24'h000000, st_q.rf[bk][al].flg};
            `CMR_B_B:   st_d.rd = {24'h000000, st_q.rf[bk][al].p1[15:8]};
            `CMR_B_C:   st_d.rd = {24'h000000, st_q.rf[bk][al].p1[7:0]};
            `CMR_B_D:   st_d.rd = {24'h000000, st_q.rf[bk][al].p2[15:8]};
            `CMR_B_E:   st_d.rd = {24'h000000, st_q.rf[bk][al].p2[7:0]};
            `CMR_B_H:   st_d.rd = {24'h000000, st_q.rf[bk][al].hl[15:8]};
            `CMR_B_L:   st_d.rd = {24'h000000, st_q.rf[bk][al].hl[7:0]};
            `CMR_B_IXU: st_d.rd = {24'h000000, st_q.rf[bk][al].ix[15:8]};
            `CMR_B_IXL: st_d.rd = {24'h000000, st_q.rf[bk][al].ix[7:0]};
            `CMR_B_IYU: st_d.rd = {24'h000000, st_q.rf[bk][al].iy[15:8]};
            `CMR_B_IYL: st_d.rd = {24'h000000, st_q.rf[bk][al].iy[7:0]};
            `CMR_B_R:   st_d.rd = {24'h000000, st_q.rr};
            default:    st_d.rd = 32'h0000_0000;
          endcase
        end
        CMR_WR_W: st_d = put_w(st_d, bk, al, sel_a_in, mrg(lw, wa, data_in));
        CMR_WR_B: begin
          case (sel_a_in)
            `CMR_B_A:   st_d.rf[bk][al].acc = data_in[7:0];
            `CMR_B_F:   st_d.rf[bk][al].flg = data_in[7:0];
            `CMR_B_B:   st_d.rf[bk][al].p1[15:8] = data_in[7:0];
            `CMR_B_C:   st_d.rf[bk][al].p1[7:0] = data_in[7:0];
            `CMR_B_D:   st_d.rf[bk][al].p2[15:8] = data_in[7:0];
            `CMR_B_E:   st_d.rf[bk][al].p2[7:0] = data_in[7:0];
            `CMR_B_H:   st_d.rf[bk][al].hl[15:8] = data_in[7:0];
            `CMR_B_L:   st_d.rf[bk][al].hl[7:0] = data_in[7:0];
            `CMR_B_IXU: st_d.rf[bk][al].ix[15:8] = data_in[7:0];
            `CMR_B_IXL: st_d.rf[bk][al].ix[7:0] = data_in[7:0];
            `CMR_B_IYU: st_d.rf[bk][al].iy[15:8] = data_in[7:0];
            `CMR_B_IYL: st_d.rf[bk][al].iy[7:0] = data_in[7:0];
            `CMR_B_R:   st_d.rr = data_in[7:0];
            default:    st_d.rr = st_q.rr;
          endcase
        end
        CMR_XCH_W: begin
          // both halves swap only in long mode
          st_d = put_w(st_d, bk, al, sel_a_in, mrg(lw, wa, wb));
          st_d = put_w(st_d, bk, al, sel_b_in, mrg(lw, wb, wa));
        end
        CMR_EX_FILE: st_d.sr[`CMR_SR_ALT + bk] = !al;
        CMR_SET_EXT: st_d.sr[`CMR_SR_EXT] = 1'b1;
        CMR_SET_LW:  st_d.sr[`CMR_SR_LW] = 1'b1;
        CMR_SET_W:   st_d.sr[`CMR_SR_LW] = 1'b0;
        CMR_ADD16: begin
          // word addition stays 16 bits whatever the modes say
          sum  = {1'b0, st_q.rf[bk][al].hl[15:0]} + {1'b0, wa[15:0]};
          hsum = {1'b0, st_q.rf[bk][al].hl[3:0]} + {1'b0, wa[3:0]};
          res  = sum[15:0];
          st_d.rf[bk][al].hl[15:0] = res;
          st_d.rf[bk][al].flg[`CMR_F_C]  = sum[16];
          st_d.rf[bk][al].flg[`CMR_F_N]  = 1'b0;
          st_d.rf[bk][al].flg[`CMR_F_PV] = (st_q.rf[bk][al].hl[15] == wa[15]) &&
                                           (res[15] != wa[15]);
          st_d.rf[bk][al].flg[`CMR_F_H]  = hsum[4];
          st_d.rf[bk][al].flg[`CMR_F_Z]  = (res == 16'h0000);
          st_d.rf[bk][al].flg[`CMR_F_S]  = res[15];
        end
        CMR_MUL16: begin
          st_d.rf[bk][al].hl = st_q.rf[bk][al].hl[15:0] * wa[15:0];
        end
        CMR_ADDR: begin
          ea = aadd(abase(st_q, sel_a_in, nat), data_in, nat);
          st_d.addr   = ea[23:0];
          st_d.addr_v = 1'b1;
        end
        CMR_PC_INC: begin
          st_d.pc   = aadd(abase(st_q, `CMR_W_PC, nat), data_in, nat);
          st_d.addr = st_d.pc[23:0];
          st_d.addr_v = 1'b1;
        end
        CMR_SP_ADJ: st_d.sp = aadd(abase(st_q, `CMR_W_SP, nat), data_in, nat);
        CMR_IO_OUT: begin
          st_d.io   = wa[15:0];
          st_d.io_v = 1'b1;
        end
        CMR_MEM_ST: st_d.mem = {wa[7:0], wa[15:8]};
        CMR_VEC: begin
          ea = abase(st_q, `CMR_W_IR, nat);
          if (st_q.sr[`CMR_SR_IM] == `CMR_IM_3) begin
            st_d.vec = {ea[31:16], irq_vec_in};
          end else begin
            st_d.vec = {ea[31:8], irq_vec_in[7:0]};
          end
        end
        CMR_VEC_ASG: begin
          ea = abase(st_q, `CMR_W_IR, nat);
          st_d.vec = {ea[31:16], ea[15:9], 2'h0, irq_line_in, 5'h00};
        end
        default: st_d.rd = st_q.rd;
      endcase
    end
  end

  // single state register; reset gives compatible, 16-bit, bank 0, primary file
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q        <= '0;
      st_q.sr     <= `CMR_SR_RST;
      st_q.wait_r <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign rd_data_out         = st_q.rd;
  assign addr_out            = st_q.addr;
  assign addr_valid_out      = st_q.addr_v;
  assign io_data_out         = st_q.io;
  assign io_valid_out        = st_q.io_v;
  assign mem_data_out        = st_q.mem;
  assign vec_addr_out        = st_q.vec;
  assign ext_mode_out        = st_q.sr[`CMR_SR_EXT];
  assign long_mode_out       = st_q.sr[`CMR_SR_LW];
  assign irq_mode_out        = st_q.sr[`CMR_SR_IM];
  assign avs_readdata_out    = st_q.bus_rd;
  assign avs_waitrequest_out = st_q.wait_r;
endmodule
`default_nettype wire

// [inc/cmr_defs.svh]
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH
`define CMR_SR_RST   32'h0000_0000
`define CMR_SR_MASK  32'h0000_0F7F
`define CMR_SR_EXT   0
`define CMR_SR_LW    1
`define CMR_SR_BANK  3:2
`define CMR_SR_IM    5:4
`define CMR_SR_ALT   8
`define CMR_A_SR     3'h0
`define CMR_A_PC     3'h1
`define CMR_A_SP     3'h2
`define CMR_A_IR     3'h3
`define CMR_A_RR     3'h4
`define CMR_W_BC     4'h0
`define CMR_W_DE     4'h1
`define CMR_W_HL     4'h2
`define CMR_W_IX     4'h3
`define CMR_W_IY     4'h4
`define CMR_W_SP     4'h5
`define CMR_W_IR     4'h6
`define CMR_W_PC     4'h7
`define CMR_B_A      4'h0
`define CMR_B_F      4'h1
`define CMR_B_B      4'h2
`define CMR_B_C      4'h3
`define CMR_B_D      4'h4
`define CMR_B_E      4'h5
`define CMR_B_H      4'h6
`define CMR_B_L      4'h7
`define CMR_B_IXU    4'h8
`define CMR_B_IXL    4'h9
`define CMR_B_IYU    4'hA
`define CMR_B_IYL    4'hB
`define CMR_B_R      4'hC
`define CMR_F_C      0
`define CMR_F_N      1
`define CMR_F_PV     2
`define CMR_F_H      4
`define CMR_F_Z      6
`define CMR_F_S      7
`define CMR_IM_2     2'h2
`define CMR_IM_3     2'h3
`endif

// [inc/cmr_pkg.sv]
`include "cmr_defs.svh"
package cmr_pkg;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  flg;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] hl;
    logic [31:0] ix;
    logic [31:0] iy;
  } cmr_file_t;
  typedef enum logic [4:0] {
    CMR_NOP = 5'h00, CMR_RD_W = 5'h01, CMR_RD_B = 5'h02, CMR_WR_W = 5'h03,
    CMR_WR_B = 5'h04, CMR_XCH_W = 5'h05, CMR_EX_FILE = 5'h06, CMR_SET_EXT = 5'h07,
    CMR_SET_LW = 5'h08, CMR_SET_W = 5'h09, CMR_ADD16 = 5'h0A, CMR_MUL16 = 5'h0B,
    CMR_ADDR = 5'h0C, CMR_PC_INC = 5'h0D, CMR_SP_ADJ = 5'h0E, CMR_IO_OUT = 5'h0F,
    CMR_MEM_ST = 5'h10, CMR_VEC = 5'h11, CMR_VEC_ASG = 5'h12
  } cmr_op_t;
  typedef struct packed {
    cmr_file_t [3:0][1:0] rf;
    logic [31:0] sp;
    logic [31:0] pc;
    logic [31:0] ir;
    logic [7:0]  rr;
    logic [31:0] sr;
    logic [31:0] rd;
    logic [23:0] addr;
    logic        addr_v;
    logic [15:0] io;
    logic        io_v;
    logic [15:0] mem;
    logic [31:0] vec;
    logic        wait_r;
    logic [31:0] bus_rd;
  } cmr_state_t;
endpackage

// [testbench/cmr_core_regs_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module cmr_core_regs_asserts
  import cmr_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        op_valid_in,
  input wire cmr_op_t     op_in,
  input wire logic [2:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        addr_valid_out,
  input wire logic        io_valid_out,
  input wire logic        ext_mode_out,
  input wire logic        long_mode_out,
  input wire logic [1:0]  irq_mode_out,
  input wire logic        avs_waitrequest_out
);
  logic sr_wr;
  logic cmd_set;
  // a bus write to the select register completes this cycle
  assign sr_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 3'h0;
  assign cmd_set = op_valid_in && op_in == CMR_SET_EXT;
  default clocking cb @(posedge mclk_in); endclocking

  property p_rst; rst_in |=> !ext_mode_out && !long_mode_out && irq_mode_out == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("modes not cleared");
  property p_ext_hold; disable iff (rst_in) ext_mode_out |=> ext_mode_out; endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended mode left");
  property p_ext_set; disable iff (rst_in) cmd_set |=> ext_mode_out; endproperty
  a_ext_set: assert property (p_ext_set) else $error("extended mode not entered");
  property p_lw_set; disable iff (rst_in) op_valid_in && op_in == CMR_SET_LW |=> long_mode_out;
  endproperty
  a_lw_set: assert property (p_lw_set) else $error("long mode not set");
  property p_lw_clr; disable iff (rst_in) op_valid_in && op_in == CMR_SET_W |=> !long_mode_out;
  endproperty
  a_lw_clr: assert property (p_lw_clr) else $error("long mode not cleared");
  property p_addr_v;
    disable iff (rst_in) addr_valid_out == $past(op_valid_in && (op_in == CMR_ADDR ||
      op_in == CMR_PC_INC));
  endproperty
  a_addr_v: assert property (p_addr_v) else $error("address strobe wrong");
  property p_io_v; disable iff (rst_in) op_valid_in && op_in == CMR_IO_OUT |=> io_valid_out;
  endproperty
  a_io_v: assert property (p_io_v) else $error("io strobe missing");
  property p_wait;
    disable iff (rst_in) (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_ro;
    disable iff (rst_in) avs_write_in && !avs_waitrequest_out && avs_address_in != 3'h0
      && !op_valid_in |=> $stable(long_mode_out) && $stable(irq_mode_out);
  endproperty
  a_ro: assert property (p_ro) else $error("mode changed by other address");
  property p_sr_wr;
    disable iff (rst_in) sr_wr && avs_byteenable_in[0] && !op_valid_in |=> long_mode_out ==
      $past(avs_writedata_in[1]) && irq_mode_out == $past(avs_writedata_in[5:4]);
  endproperty
  a_sr_wr: assert property (p_sr_wr) else $error("select write lost");
endmodule
bind cmr_core_regs cmr_core_regs_asserts chk_u (.mclk_in, .rst_in, .op_valid_in, .op_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .addr_valid_out, .io_valid_out, .ext_mode_out, .long_mode_out, .irq_mode_out,
  .avs_waitrequest_out);
`default_nettype wire

// [testbench/cmr_core_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cmr_defs.svh"
module cmr_core_regs_tb;
  import cmr_pkg::*;
  logic        mclk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        avs_read_in = 1'h0;
  logic        avs_write_in = 1'h0;
  logic [2:0]  avs_address_in = 3'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [31:0] rd_data_out, vec_addr_out, avs_readdata_out;
  logic [23:0] addr_out;
  logic [15:0] io_data_out, mem_data_out, irq_vec;
  logic [3:0]  sel_a, sel_b;
  logic [31:0] data;
  logic [1:0]  irq_mode_out, irq_line;
  logic        op_valid, pfx_v, pfx_l, addr_valid_out, io_valid_out;
  logic        ext_mode_out, long_mode_out, avs_waitrequest_out;
  cmr_op_t     op;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;

  cmr_dec_model dec_u (.mclk_in, .op_out(op), .op_valid_out(op_valid), .sel_a_out(sel_a),
    .sel_b_out(sel_b), .data_out(data), .pfx_valid_out(pfx_v), .pfx_long_out(pfx_l),
    .irq_vec_out(irq_vec), .irq_line_out(irq_line));
  cmr_core_regs dut_u (.mclk_in, .rst_in, .op_valid_in(op_valid), .op_in(op),
    .sel_a_in(sel_a), .sel_b_in(sel_b), .data_in(data), .pfx_valid_in(pfx_v),
    .pfx_long_in(pfx_l), .irq_vec_in(irq_vec), .irq_line_in(irq_line), .rd_data_out,
    .addr_out, .addr_valid_out, .io_data_out, .io_valid_out, .mem_data_out, .vec_addr_out,
    .ext_mode_out, .long_mode_out, .irq_mode_out, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out);

  // free-running clock and a hang limit well past the expected run
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // avalon master: hold until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask
  task automatic rbus(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wbus(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic cmd(input cmr_op_t o, input logic [3:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic [1:0] p);
    dec_u.issue(o, a, b, d, p);
    @(negedge mclk_in);
  endtask
  task automatic rd(input cmr_op_t o, input logic [3:0] a, input logic [31:0] exp);
    cmd(o, a, 4'h0, 32'h0, 2'h0);
    chk(rd_data_out, exp);
  endtask

  // main sequence: word mode, exchange, arithmetic, addressing, banks, vectors
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      rbus(i[2:0], 32'h0);
    end
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'h1234_5678, 2'h0);
    rd(CMR_RD_W, `CMR_W_HL, 32'h0000_5678);
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'hAABB_CCDD, 2'h3);
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'h1111_2222, 2'h0);
    rd(CMR_RD_W, `CMR_W_HL, 32'hAABB_2222);
    cmd(CMR_WR_W, `CMR_W_BC, 4'h0, 32'h1111_AAAA, 2'h3);
    cmd(CMR_WR_W, `CMR_W_DE, 4'h0, 32'h2222_BBBB, 2'h3);
    cmd(CMR_XCH_W, `CMR_W_BC, `CMR_W_DE, 32'h0, 2'h0);
    rd(CMR_RD_W, `CMR_W_BC, 32'h1111_BBBB);
    cmd(CMR_SET_LW, 4'h0, 4'h0, 32'h0, 2'h0);
    cmd(CMR_XCH_W, `CMR_W_BC, `CMR_W_DE, 32'h0, 2'h0);
    rd(CMR_RD_W, `CMR_W_BC, 32'h2222_AAAA);
    rd(CMR_RD_W, `CMR_W_DE, 32'h1111_BBBB);
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'h0001_FFFF, 2'h0);
    cmd(CMR_ADD16, `CMR_W_BC, 4'h0, 32'h0, 2'h0);
    rd(CMR_RD_W, `CMR_W_HL, 32'h0001_AAA9);
    rd(CMR_RD_B, `CMR_B_F, 32'h0000_0091);
    cmd(CMR_MUL16, `CMR_W_BC, 4'h0, 32'h0, 2'h0);
    rd(CMR_RD_W, `CMR_W_HL, 32'h0000_AAA9 * 32'h0000_AAAA);
    cmd(CMR_PC_INC, 4'h0, 4'h0, 32'h0000_FFFF, 2'h0);
    cmd(CMR_PC_INC, 4'h0, 4'h0, 32'h0000_0002, 2'h0);
    chk(32'(addr_out), 32'h0000_0001);
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'hFF12_FFFF, 2'h0);
    cmd(CMR_ADDR, `CMR_W_HL, 4'h0, 32'h0000_0001, 2'h0);
    chk(32'(addr_out), 32'h0012_0000);
    cmd(CMR_WR_W, `CMR_W_SP, 4'h0, 32'h0005_FFF0, 2'h0);
    cmd(CMR_ADDR, `CMR_W_SP, 4'h0, 32'h0000_0020, 2'h0);
    chk(32'(addr_out), 32'h0000_0010);
    rbus(3'h2, 32'h0005_FFF0);
    cmd(CMR_SP_ADJ, 4'h0, 4'h0, 32'h0000_0020, 2'h0);
    rbus(3'h2, 32'h0000_0010);
    wbus(3'h1, 32'h0000_BEEF);
    rbus(3'h1, 32'h0000_0001);
    cmd(CMR_SET_EXT, 4'h0, 4'h0, 32'h0, 2'h0);
    wbus(3'h0, 32'h0000_0002);
    rbus(3'h0, 32'h0000_0003);
    cmd(CMR_PC_INC, 4'h0, 4'h0, 32'h0000_FFFF, 2'h0);
    rbus(3'h1, 32'h0001_0000);
    cmd(CMR_ADDR, `CMR_W_HL, 4'h0, 32'h0000_0001, 2'h0);
    chk(32'(addr_out), 32'h0013_0000);
    wbus(3'h0, 32'h0000_0007);
    rd(CMR_RD_W, `CMR_W_HL, 32'h0);
    cmd(CMR_WR_W, `CMR_W_HL, 4'h0, 32'h0000_0055, 2'h0);
    wbus(3'h0, 32'h0000_0003);
    rd(CMR_RD_W, `CMR_W_HL, 32'hFF12_FFFF);
    cmd(CMR_EX_FILE, 4'h0, 4'h0, 32'h0, 2'h0);
    rbus(3'h0, 32'h0000_0103);
    rd(CMR_RD_W, `CMR_W_HL, 32'h0);
    cmd(CMR_EX_FILE, 4'h0, 4'h0, 32'h0, 2'h0);
    cmd(CMR_IO_OUT, `CMR_W_DE, 4'h0, 32'h0, 2'h0);
    chk(32'(io_data_out), 32'h0000_BBBB);
    cmd(CMR_WR_W, `CMR_W_IX, 4'h0, 32'h1234_5678, 2'h0);
    cmd(CMR_MEM_ST, `CMR_W_IX, 4'h0, 32'h0, 2'h0);
    chk(32'(mem_data_out), 32'h0000_7856);
    rd(CMR_RD_B, `CMR_B_IXU, 32'h0000_0056);
    rd(CMR_RD_B, `CMR_B_IXL, 32'h0000_0078);
    cmd(CMR_WR_W, `CMR_W_IR, 4'h0, 32'hABCD_1234, 2'h0);
    wbus(3'h0, 32'h0000_0023);
    cmd(CMR_VEC, 4'h0, 4'h0, 32'h0000_5566, 2'h0);
    chk(vec_addr_out, 32'hABCD_1266);
    wbus(3'h0, 32'h0000_0033);
    cmd(CMR_VEC, 4'h0, 4'h0, 32'h0000_5566, 2'h0);
    chk(vec_addr_out, 32'hABCD_5566);
    cmd(CMR_VEC_ASG, 4'h0, 4'h2, 32'h0, 2'h0);
    chk(vec_addr_out, 32'hABCD_1240);
    cmd(CMR_WR_B, `CMR_B_R, 4'h0, 32'h0000_005A, 2'h0);
    rd(CMR_RD_B, `CMR_B_R, 32'h0000_005A);
    rbus(3'h4, 32'h0000_005A);
    cmd(CMR_SET_W, 4'h0, 4'h0, 32'h0, 2'h0);
    rbus(3'h0, 32'h0000_0031);
    // upper lanes only: the low select byte must keep its modes
    avs_byteenable_in <= 4'hE;
    wbus(3'h0, 32'hFFFF_FF00);
    avs_byteenable_in <= 4'hF;
    rbus(3'h0, 32'h0000_0F31);
    @(posedge mclk_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'h0;
    rbus(3'h0, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire

// [testbench/cmr_dec_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cmr_dec_model
  import cmr_pkg::*;
(
  input  wire logic        mclk_in,
  output var cmr_op_t      op_out,
  output logic             op_valid_out,
  output logic      [3:0]  sel_a_out,
  output logic      [3:0]  sel_b_out,
  output logic      [31:0] data_out,
  output logic             pfx_valid_out,
  output logic             pfx_long_out,
  output logic      [15:0] irq_vec_out,
  output logic      [1:0]  irq_line_out
);
  // idle decoder at time zero
  initial begin
    op_out = CMR_NOP;
    {op_valid_out, sel_a_out, sel_b_out, data_out, pfx_valid_out, pfx_long_out} = '0;
    {irq_vec_out, irq_line_out} = '0;
  end
  // one command per call; vector and line ride on data and second id
  task automatic issue(input cmr_op_t o, input logic [3:0] a, input logic [3:0] b,
                       input logic [31:0] d, input logic [1:0] p);
    @(posedge mclk_in);
    op_out <= o;
    op_valid_out <= 1'h1;
    sel_a_out <= a;
    sel_b_out <= b;
    data_out <= d;
    {pfx_valid_out, pfx_long_out} <= p;
    irq_vec_out <= d[15:0];
    irq_line_out <= b[1:0];
    @(posedge mclk_in);
    // released data shows junk so a stale value never passes for a fresh one
    op_valid_out <= 1'h0;
    data_out <= ~d;
    pfx_valid_out <= 1'h0;
  endtask
endmodule
`default_nettype wire
